//--- src/cgat_addr_gen.sv
`timescale 1ns/100ps
`default_nettype none
module cgat_addr_gen (
    // configuration
    input wire logic [15:0] cg_base_address,
    input wire logic tall_font_select,
    input wire logic code_bit6_fold,
    input wire logic rom_enable,
    // lookup
    input wire logic [7:0] char_code,
    input wire logic [3:0] row_index,
    output logic [15:0] font_addr,
    output logic use_cgram
);
    wire logic [7:0] eff_code;
    wire logic [15:0] code_part;
    wire logic [15:0] row_part;

    // second ram area e0..ff folds onto a0..bf, making the areas contiguous
    assign eff_code = (code_bit6_fold && char_code[7] && char_code[6]) ?
        {char_code[7], 1'b0, char_code[5:0]} : char_code;
    assign code_part = tall_font_select ? {4'h0, eff_code, 4'h0}
        : {5'h00, eff_code, 3'h0};
    assign row_part = tall_font_select ? {12'h000, row_index}
        : {13'h0000, row_index[2:0]};
    // carry out of bit 15 is dropped by the 16-bit target
    assign font_addr = cg_base_address + code_part + row_part;
    // 80..9f and e0..ff go to ram; without the rom every code does
    assign use_cgram = rom_enable ?
        (char_code[7] && (char_code[6] == char_code[5]))
        : 1'b1;
endmodule // cgat_addr_gen
`default_nettype wire

//--- src/cgat_params.svh
`ifndef CGAT_PARAMS_SVH
`define CGAT_PARAMS_SVH

// =====================================================================
// register byte offsets
`define CGAT_OFF_CTRL 8'h00
`define CGAT_OFF_CMD 8'h04
`define CGAT_OFF_PARAM 8'h08
`define CGAT_OFF_CG_BASE 8'h0c
`define CGAT_OFF_CURSOR 8'h10
`define CGAT_OFF_FIELD 8'h14
`define CGAT_OFF_LINE 8'h18
`define CGAT_OFF_STATUS 8'h1c

// =====================================================================
// control register bit positions
`define CGAT_CTRL_FOLD 0
`define CGAT_CTRL_TALL 1
`define CGAT_CTRL_ROM 2

// =====================================================================
// command codes
`define CGAT_CMD_CG_BASE 8'h5c
`define CGAT_CMD_CSR_DIR 8'h4c
`define CGAT_CMD_CSR_WRITE 8'h46
`define CGAT_CMD_MEM_WRITE 8'h42

// =====================================================================
// reset values
`define CGAT_RST_FOLD 1'b0
`define CGAT_RST_TALL 1'b0
`define CGAT_RST_ROM 1'b1
`define CGAT_RST_CG_BASE 16'h0000
`define CGAT_RST_CURSOR 16'h0000
`define CGAT_RST_FX 4'h7
`define CGAT_RST_FY 4'h7
`define CGAT_RST_VC 8'h27
`define CGAT_RST_CR 8'h27
`define CGAT_RST_TCR 8'h2f

// =====================================================================
// line timing margin in bytes between display and total line length
`define CGAT_LINE_MARGIN 8'h04

`endif

//--- src/cgat_pkg.sv
`default_nettype none
package cgat_pkg;
    typedef enum logic [1:0] {
        CGAT_IDLE = 2'b00,
        CGAT_BASE = 2'b01,
        CGAT_CSR = 2'b11,
        CGAT_MWR = 2'b10
    } cgat_cmd_state_t;
endpackage
`default_nettype wire

//--- src/cgat_top.sv
// Behaviour
// - tall fonts: code at bits 11..4, 4-bit row at 3..0, plus base.
// - short fonts: code at bits 10..3, 3-bit row at 2..0, plus base.
// - with folding on, code bit 6 cleared for the second ram area.
// - with rom in use, codes 80-9f and e0-ff go to ram, rest rom.
// - without the rom, every code is fetched from ram.
// - command 4c only returns the sequencer to idle; each data byte steps address.
// - size and count fields hold the quantity minus one.
// - leftover right-edge pixels are blanked whatever memory holds.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cgat_params.svh"
module cgat_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // font lookup from the display scan logic
    input wire logic fetch_req,
    input wire logic [7:0] fetch_code,
    input wire logic [3:0] fetch_row,
    output logic fetch_ack,
    output logic [15:0] fetch_addr,
    output logic fetch_cgram,
    // display memory write port
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    // pixel path
    input wire logic [12:0] pixel_x,
    input wire logic pixel_in,
    output logic pixel_out
);
    // =================================================================
    // state
    logic code_bit6_fold;
    logic tall_font_select;
    logic rom_enable;
    logic [15:0] cg_base_address;
    logic [15:0] cursor;
    logic [3:0] char_field_width;
    logic [3:0] char_field_height;
    logic [7:0] chars_per_line;
    logic [7:0] bytes_per_line;
    logic [7:0] total_line_length;
    logic param_hi;
    cgat_pkg::cgat_cmd_state_t cmd_state;
    cgat_pkg::cgat_cmd_state_t next_cmd_state;

    // =================================================================
    // apb decode
    wire logic access;
    wire logic wr;
    wire logic hit;
    wire logic wr_ctrl;
    wire logic wr_cmd;
    wire logic wr_param;
    wire logic wr_field;
    wire logic wr_line;
    wire logic [7:0] wbyte;

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign hit = (paddr == `CGAT_OFF_CTRL) || (paddr == `CGAT_OFF_CMD) ||
        (paddr == `CGAT_OFF_PARAM) || (paddr == `CGAT_OFF_CG_BASE) ||
        (paddr == `CGAT_OFF_CURSOR) || (paddr == `CGAT_OFF_FIELD) ||
        (paddr == `CGAT_OFF_LINE) || (paddr == `CGAT_OFF_STATUS);
    assign wr_ctrl = wr && (paddr == `CGAT_OFF_CTRL);
    assign wr_cmd = wr && (paddr == `CGAT_OFF_CMD);
    assign wr_param = wr && (paddr == `CGAT_OFF_PARAM);
    assign wr_field = wr && (paddr == `CGAT_OFF_FIELD);
    assign wr_line = wr && (paddr == `CGAT_OFF_LINE);
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    // =================================================================
    // line timing: fields hold quantity minus one
    wire logic [4:0] fx_count;
    wire logic [8:0] vc_count;
    wire logic [12:0] blank_start;
    wire logic [8:0] cr_expected;
    wire logic timing_ok;
    wire logic cr_match;

    assign fx_count = {1'b0, char_field_width} + 5'h01;
    assign vc_count = {1'b0, chars_per_line} + 9'h001;
    // first pixel past the last whole character field
    assign blank_start = 13'({4'h0, vc_count} * {8'h00, fx_count});
    // field width over 8 rounded up is 1 or 2 bytes
    assign cr_expected = fx_count[4] || (fx_count[3:0] > 4'h8) ?
        {vc_count[7:0], 1'b0} : vc_count;
    assign cr_match = ({1'b0, bytes_per_line} + 9'h001) == cr_expected;
    // [TC/R] >= [C/R] + 4 with both stored minus one
    assign timing_ok = {1'b0, total_line_length} >=
        ({1'b0, bytes_per_line} + {1'b0, `CGAT_LINE_MARGIN});

    // =================================================================
    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            case (paddr)
                `CGAT_OFF_CTRL: prdata = {29'h0000_0000, rom_enable,
                    tall_font_select, code_bit6_fold};
                `CGAT_OFF_CMD: prdata = {30'h0000_0000, cmd_state};
                `CGAT_OFF_CG_BASE: prdata = {16'h0000, cg_base_address};
                `CGAT_OFF_CURSOR: prdata = {16'h0000, cursor};
                `CGAT_OFF_FIELD: prdata = {8'h00, chars_per_line,
                    4'h0, char_field_height, 4'h0, char_field_width};
                `CGAT_OFF_LINE: prdata = {16'h0000, total_line_length,
                    bytes_per_line};
                `CGAT_OFF_STATUS: prdata = {3'h0, blank_start, 14'h0000,
                    cr_match, timing_ok};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // =================================================================
    // command sequencer
    always_comb begin
        next_cmd_state = cmd_state;
        if (wr_cmd) begin
            case (wbyte)
                `CGAT_CMD_CG_BASE: next_cmd_state = cgat_pkg::CGAT_BASE;
                `CGAT_CMD_CSR_WRITE: next_cmd_state = cgat_pkg::CGAT_CSR;
                `CGAT_CMD_MEM_WRITE: next_cmd_state = cgat_pkg::CGAT_MWR;
                default: next_cmd_state = cgat_pkg::CGAT_IDLE;
            endcase
        end else if (wr_param && param_hi) begin
            case (cmd_state)
                cgat_pkg::CGAT_BASE: next_cmd_state = cgat_pkg::CGAT_IDLE;
                cgat_pkg::CGAT_CSR: next_cmd_state = cgat_pkg::CGAT_IDLE;
                default: next_cmd_state = cmd_state;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_state <= cgat_pkg::CGAT_IDLE;
            param_hi <= 1'b0;
        end else begin
            cmd_state <= next_cmd_state;
            if (wr_cmd) begin
                param_hi <= 1'b0;
            end else if (wr_param) begin
                param_hi <= !param_hi;
            end
        end
    end

    // two-byte loads take the low byte first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cg_base_address <= `CGAT_RST_CG_BASE;
        end else if (wr_param && cmd_state == cgat_pkg::CGAT_BASE) begin
            if (param_hi) begin
                cg_base_address[15:8] <= wbyte;
            end else begin
                cg_base_address[7:0] <= wbyte;
            end
        end
    end

    // cursor only ever moves right: 4c is accepted and only returns the sequencer to idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cursor <= `CGAT_RST_CURSOR;
        end else if (wr_param && cmd_state == cgat_pkg::CGAT_CSR) begin
            if (param_hi) begin
                cursor[15:8] <= wbyte;
            end else begin
                cursor[7:0] <= wbyte;
            end
        end else if (wr_param && cmd_state == cgat_pkg::CGAT_MWR) begin
            cursor <= cursor + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= wr_param && cmd_state == cgat_pkg::CGAT_MWR;
            if (wr_param && cmd_state == cgat_pkg::CGAT_MWR) begin
                mem_addr <= cursor;
                mem_wdata <= wbyte;
            end
        end
    end

    // =================================================================
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_bit6_fold <= `CGAT_RST_FOLD;
            tall_font_select <= `CGAT_RST_TALL;
            rom_enable <= `CGAT_RST_ROM;
            char_field_width <= `CGAT_RST_FX;
            char_field_height <= `CGAT_RST_FY;
            chars_per_line <= `CGAT_RST_VC;
            bytes_per_line <= `CGAT_RST_CR;
            total_line_length <= `CGAT_RST_TCR;
        end else begin
            if (wr_ctrl) begin
                code_bit6_fold <= pwdata[`CGAT_CTRL_FOLD];
                tall_font_select <= pwdata[`CGAT_CTRL_TALL];
                rom_enable <= pwdata[`CGAT_CTRL_ROM];
            end
            if (wr_field) begin
                char_field_width <= pwdata[3:0];
                char_field_height <= pwdata[11:8];
                chars_per_line <= pwdata[23:16];
            end
            if (wr_line) begin
                bytes_per_line <= pwdata[7:0];
                total_line_length <= pwdata[15:8];
            end
        end
    end

    // =================================================================
    // font lookup
    wire logic [15:0] gen_addr;
    wire logic gen_cgram;

    cgat_addr_gen u_addr_gen (
        .cg_base_address(cg_base_address),
        .tall_font_select(tall_font_select),
        .code_bit6_fold(code_bit6_fold),
        .rom_enable(rom_enable),
        .char_code(fetch_code),
        .row_index(fetch_row),
        .font_addr(gen_addr),
        .use_cgram(gen_cgram)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_ack <= 1'b0;
            fetch_addr <= 16'h0000;
            fetch_cgram <= 1'b0;
            pixel_out <= 1'b0;
        end else begin
            fetch_ack <= fetch_req;
            if (fetch_req) begin
                fetch_addr <= gen_addr;
                fetch_cgram <= gen_cgram;
            end
            pixel_out <= pixel_in && (pixel_x < blank_start);
        end
    end

    // =================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_base_hi;
        wr_param && cmd_state == cgat_pkg::CGAT_BASE && param_hi;
    endsequence
    sequence s_mwr_byte;
        wr_param && cmd_state == cgat_pkg::CGAT_MWR;
    endsequence

    AST_TALL_ADDR: assert property (fetch_req && tall_font_select &&
        !code_bit6_fold |=> fetch_addr == 16'($past(cg_base_address) +
        {4'h0, $past(fetch_code), $past(fetch_row)}))
        else $error("tall font address wrong");
    AST_SHORT_ADDR: assert property (fetch_req && !tall_font_select &&
        !code_bit6_fold |=> fetch_addr == 16'($past(cg_base_address) +
        {5'h00, $past(fetch_code), $past(fetch_row[2:0])}))
        else $error("short font address wrong");
    AST_FOLD: assert property (fetch_req && code_bit6_fold &&
        tall_font_select && fetch_code[7:6] == 2'b11 |=> fetch_addr ==
        16'($past(cg_base_address) + {4'h0, 2'b10, $past(fetch_code[5:0]),
        $past(fetch_row)}))
        else $error("bit 6 not folded");
    AST_ROUTE: assert property (fetch_req && rom_enable |=>
        fetch_ack && fetch_cgram == ($past(fetch_code) inside
        {[8'h80:8'h9f], [8'he0:8'hff]}))
        else $error("rom or ram routing wrong");
    AST_ALL_RAM: assert property (fetch_req && !rom_enable |=>
        fetch_cgram)
        else $error("code not sent to ram");
    AST_BASE_HI: assert property (s_base_hi |=>
        cg_base_address[15:8] == $past(wbyte) &&
        cmd_state == cgat_pkg::CGAT_IDLE)
        else $error("base high byte not taken");
    AST_ROW_STEP: assert property (s_mwr_byte |=> mem_we &&
        mem_addr == $past(cursor) && mem_wdata == $past(wbyte) &&
        cursor == 16'($past(cursor) + 16'h0001))
        else $error("glyph row write or step wrong");
    AST_BLANK: assert property (pixel_x >= blank_start |=>
        !pixel_out)
        else $error("right edge not blanked");
    AST_SUM16: assert property (fetch_req && tall_font_select &&
        !code_bit6_fold |=> fetch_addr == 16'({1'b0, $past(cg_base_address)}
        + {5'h00, $past(fetch_code), $past(fetch_row)}))
        else $error("font address carry not dropped");
endmodule // cgat_top
`default_nettype wire

//--- verif/cgat_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cgat_host_model (
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // =================================================================
    // one apb transfer, held until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait limit here: only the bench watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows junk, not the old request
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // cgat_host_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "cgat_params.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic fetch_req, fetch_ack, fetch_cgram, mem_we, err;
    logic [7:0] fetch_code, mem_wdata;
    logic [3:0] fetch_row;
    logic [15:0] fetch_addr, mem_addr, base;
    logic [12:0] pixel_x;
    logic pixel_in, pixel_out, pv, pv_d;
    int errors, tests_run;
    logic [16:0] fq[$];
    logic [23:0] mq[$];
    logic pq[$];
    logic [7:0] codes [10] = '{8'h00, 8'h7f, 8'h80, 8'h9f, 8'ha0,
                               8'hdf, 8'he0, 8'hff, 8'hc5, 8'h3a};

    cgat_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_req(fetch_req),
        .fetch_code(fetch_code), .fetch_row(fetch_row),
        .fetch_ack(fetch_ack), .fetch_addr(fetch_addr),
        .fetch_cgram(fetch_cgram), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .pixel_x(pixel_x), .pixel_in(pixel_in),
        .pixel_out(pixel_out));
    cgat_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #5 pclk = ~pclk;

    // =================================================================
    // comparisons
    task automatic note(input logic ok, input string m);
        tests_run++;
        if (!ok) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        note(g === e, $sformatf("read %h exp %h", g, e));
    endtask
    task automatic cmp_fetch(input logic [16:0] g, input logic [16:0] e);
        note(g === e, $sformatf("fetch %h exp %h", g, e));
    endtask
    task automatic cmp_mem(input logic [23:0] g, input logic [23:0] e);
        note(g === e, $sformatf("mem write %h exp %h", g, e));
    endtask
    task automatic cmp_pix(input logic g, input logic e);
        note(g === e, $sformatf("pixel %b exp %b", g, e));
    endtask

    // =================================================================
    // bus helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic ee);
        host.xfer(1'b0, a, 32'h0, rd, err);
        cmp_reg(rd, e);
        cmp_reg({31'h0, err}, {31'h0, ee});
    endtask
    task automatic par(input logic [7:0] b);
        wr(`CGAT_OFF_PARAM, {24'h0, b});
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(`CGAT_OFF_CMD, {24'h0, c});
    endtask
    task automatic setb(input logic [15:0] b);
        cmd(`CGAT_CMD_CG_BASE);
        par(b[7:0]);
        par(b[15:8]);
        base = b;
    endtask
    task automatic load(input logic [15:0] at, input int n);
        logic [7:0] d;
        cmd(`CGAT_CMD_CSR_WRITE);
        par(at[7:0]);
        par(at[15:8]);
        cmd(`CGAT_CMD_MEM_WRITE);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            mq.push_back({at + 16'(i), d});
            par(d);
        end
    endtask

    // own model of the lookup, ctl = {rom, tall, fold}
    function automatic logic [16:0] fexp(input logic [2:0] ctl,
                                         input logic [7:0] c,
                                         input logic [3:0] r);
        logic [7:0] k;
        logic [15:0] a;
        k = (ctl[0] && c[7:6] == 2'b11) ? (c & 8'hbf) : c;
        a = ctl[1] ? {4'h0, k, 4'h0} + {12'h0, r}
                   : {5'h0, k, 3'h0} + {13'h0, r[2:0]};
        return {base + a, ctl[2] ? (c[7] && c[6] == c[5]) : 1'b1};
    endfunction
    task automatic fetch(input logic [2:0] ctl, input logic [7:0] c,
                         input logic [3:0] r);
        @(posedge pclk);
        fetch_req <= 1'b1;
        fetch_code <= c;
        fetch_row <= r;
        fq.push_back(fexp(ctl, c, r));
    endtask
    task automatic fetch_end;
        @(posedge pclk);
        fetch_req <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic close_out;
        note(fq.size() == 0 && mq.size() == 0, "results missing");
        $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // =================================================================
    // result monitor
    always @(posedge pclk) pv_d <= pv;
    always @(negedge pclk) begin
        if (fetch_ack === 1'b1) begin
            if (fq.size() == 0) note(1'b0, "unexpected fetch answer");
            else cmp_fetch({fetch_addr, fetch_cgram}, fq.pop_front());
        end
        if (mem_we === 1'b1) begin
            if (mq.size() == 0) note(1'b0, "unexpected memory write");
            else cmp_mem({mem_addr, mem_wdata}, mq.pop_front());
        end
        if (pv_d && pq.size() != 0) cmp_pix(pixel_out, pq.pop_front());
    end

    initial begin
        #200000;
        errors++;
        close_out();
    end

    // =================================================================
    // main sequence
    initial begin
        logic [7:0] cr;
        logic b;
        logic [12:0] x;
        pclk = 1'b0;
        presetn = 1'b0;
        fetch_req = 1'b0;
        fetch_code = 8'h00;
        fetch_row = 4'h0;
        pixel_x = 13'h0;
        pixel_in = 1'b0;
        pv = 1'b0;
        base = 16'h0000;
        errors = 0;
        tests_run = 0;
        void'($urandom(67577));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`CGAT_OFF_CTRL, 32'h4, 1'b0);
        rchk(`CGAT_OFF_FIELD, 32'h00270707, 1'b0);
        rchk(`CGAT_OFF_LINE, 32'h00002f27, 1'b0);
        wr(`CGAT_OFF_CG_BASE, 32'h1234);
        rchk(`CGAT_OFF_CG_BASE, 32'h0, 1'b0);
        rchk(8'h20, 32'h0, 1'b1);
        $display("test reset_values done");
        wr(`CGAT_OFF_CTRL, 32'h6);
        setb(16'h4000);
        rchk(`CGAT_OFF_CG_BASE, 32'h4000, 1'b0);
        cmd(`CGAT_CMD_CSR_DIR);
        load(16'h4800, 16);
        rchk(`CGAT_OFF_CURSOR, 32'h4810, 1'b0);
        rchk(`CGAT_OFF_CMD, 32'h2, 1'b0);
        // folded code: host clears bit 6 when placing the glyph
        wr(`CGAT_OFF_CTRL, 32'h7);
        load(base + {4'h0, 8'he5 & 8'hbf, 4'h0}, 1);
        fetch(3'h7, 8'he5, 4'h0);
        fetch_end();
        $display("test glyph_load done");
        setb(16'hf812);
        for (int c = 0; c < 8; c++) begin
            wr(`CGAT_OFF_CTRL, 32'(c));
            codes[9] = 8'($urandom);
            foreach (codes[i]) fetch(3'(c), codes[i], 4'($urandom));
            fetch_end();
        end
        $display("test lookup_matrix done");
        // 256 pixels, 42 chars of 6 pixels: 4 blank at the right
        cr = 8'(((6 + 7) / 8) * 42 - 1);
        wr(`CGAT_OFF_FIELD, 32'h00290705);
        wr(`CGAT_OFF_LINE, {16'h0, cr + `CGAT_LINE_MARGIN, cr});
        rchk(`CGAT_OFF_LINE, {16'h0, cr + `CGAT_LINE_MARGIN, cr},
             1'b0);
        // 65 lines at 60 frames a second must fit the 100 MHz clock
        note((int'(rd[15:8]) + 2) * 9 * 65 * 60 <= 100000000,
             "total line length too long for clock");
        rchk(`CGAT_OFF_STATUS, 32'h00fc0003, 1'b0);
        wr(`CGAT_OFF_LINE, {16'h0, cr + 8'h03, cr});
        rchk(`CGAT_OFF_STATUS, 32'h00fc0002, 1'b0);
        for (int i = 0; i < 200; i++) begin
            @(posedge pclk);
            b = 1'($urandom);
            x = (i < 4) ? 13'(250 + i) : 13'($urandom_range(0, 400));
            pixel_x <= x;
            pixel_in <= b;
            pv <= 1'b1;
            // 42 fields of 6 pixels: columns from 252 on are blank
            pq.push_back(b && (x < 13'h0fc));
        end
        @(posedge pclk);
        pv <= 1'b0;
        repeat (3) @(posedge pclk);
        $display("test pixel_blank done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
